//--- inc/ppf_pkg.sv
// Package for the port pin function and pullup block.
// Assumes a single 100 MHz clock domain and a synchronous active-high reset.
package ppf_pkg;
  localparam int PPF_PA_W     = 4;
  localparam int PPF_PB_W     = 6;
  localparam int PPF_PB_SMALL = 4;
  localparam int PPF_PC_W     = 2;
  localparam int PPF_PD_W     = 7;
  localparam int PPF_PD_SPI_W = 4;
  localparam int PPF_PD_TMR0  = 4;
  localparam int PPF_PE_W     = 2;
  localparam int PPF_PE_TX    = 0;
  localparam int PPF_PE_RX    = 1;
  localparam int PPF_GPIO_MAX = 21;
  localparam int PPF_SHARED   = 19;
  localparam logic PPF_PULL_RST = 1'h0;
  localparam logic PPF_RST_LVL  = 1'h0;
  localparam int PPF_RST_STRETCH = 4;
endpackage

//--- inc/ppf_pin_if.sv
// Per-port carrier between the top and the pin mux slice.
// Assumes one clock; fields are plain combinational nets.
`timescale 1ns/10ps
interface ppf_pin_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] dat;
  logic [W-1:0] pull_sel;
  logic [W-1:0] fn_en;
  logic [W-1:0] fn_oe;
  logic [W-1:0] fn_out;
  logic [W-1:0] fn_pull_force;
  logic [W-1:0] pin_oe;
  logic [W-1:0] pin_out;
  logic [W-1:0] pin_pull;
  modport top (output dir, dat, pull_sel, fn_en, fn_oe, fn_out, fn_pull_force,
               input pin_oe, pin_out, pin_pull);
  modport mux (input dir, dat, pull_sel, fn_en, fn_oe, fn_out, fn_pull_force,
               output pin_oe, pin_out, pin_pull);
endinterface

//--- core/ppf_pin_mux.sv
// Combinational pin mux for one port: drive, output enable and pullup.
// Assumes the caller registers the results before they reach the pins.
`timescale 1ns/10ps
module ppf_pin_mux
  import ppf_pkg::*;
#(
  parameter int W       = 8,
  parameter bit HAS_PULL = 1'b1
) (
  ppf_pin_if.mux p
);
  always_comb begin
    // A peripheral owns the pin outright once assigned to it.
    p.pin_oe  = (p.fn_en & p.fn_oe) | (~p.fn_en & p.dir);
    p.pin_out = (p.fn_en & p.fn_out) | (~p.fn_en & p.dat);
    // Pullup only on a non-driven pin with its select set, or when forced.
    if (HAS_PULL) begin
      p.pin_pull = (~p.pin_oe & p.pull_sel) | (p.fn_en & p.fn_pull_force);
    end else begin
      p.pin_pull = '0;
    end
  end
endmodule

//--- core/ppf_port_pins.sv
// Overview of operation
// - A low level on the system reset pin puts the device into its startup state.
// - The reset pin is bidirectional and is driven low while any internal reset is active.
// - The external interrupt pin is taken without reference to clock edges.
// - Each port A pin may be a keyboard interrupt input in any combination.
// - On ports C and D, and on port A pins not in keyboard use, a pullup is on only for an input with its select set.
// - A port A pin in keyboard interrupt use has its pullup forced on.
// - Port B has no pullups at all.
// - Each port B pin is general I/O or an analog converter input.
// - Port D low four pins may carry the SPI and each upper three pin a timer channel.
// - Port D pullups stay per-pin selectable while serving SPI or a timer.
// - The two port E pins may carry serial transmit and receive.
// - The small package has a four-bit port B with four channels and no port C.
// - General I/O totals up to twenty-one pins, nineteen of them shared.
//
// Top of the port pin function block: ports A to E, reset pin and interrupt pin.
// Assumes pins are already synchronous to i_clk, except the interrupt pin.
`timescale 1ns/10ps
module ppf_port_pins
  import ppf_pkg::*;
#(
  parameter bit SMALL_PKG = 1'b0
) (
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  // Reset pin and internal reset sources
  input  wire logic                    i_rst_pin_n,
  input  wire logic                    i_int_rst_src,
  output logic                         o_rst_pin_oe,
  output logic                         o_rst_pin_out,
  output logic                         o_sys_rst,
  // Interrupt pin
  input  wire logic                    i_irq_pin_n,
  output logic                         o_irq_latched,
  input  wire logic                    i_irq_ack,
  // Port software controls
  input  wire logic [PPF_PA_W-1:0]     i_pa_dir,
  input  wire logic [PPF_PA_W-1:0]     i_pa_dat,
  input  wire logic [PPF_PA_W-1:0]     i_pa_pull_sel,
  input  wire logic [PPF_PA_W-1:0]     i_pa_kbd_en,
  input  wire logic [PPF_PB_W-1:0]     i_pb_dir,
  input  wire logic [PPF_PB_W-1:0]     i_pb_dat,
  input  wire logic [PPF_PB_W-1:0]     i_pb_adc_en,
  input  wire logic [PPF_PC_W-1:0]     i_pc_dir,
  input  wire logic [PPF_PC_W-1:0]     i_pc_dat,
  input  wire logic [PPF_PC_W-1:0]     i_pc_pull_sel,
  input  wire logic [PPF_PD_W-1:0]     i_pd_dir,
  input  wire logic [PPF_PD_W-1:0]     i_pd_dat,
  input  wire logic [PPF_PD_W-1:0]     i_pd_pull_sel,
  input  wire logic                    i_pd_spi_en,
  input  wire logic [PPF_PD_W-1:0]     i_pd_tmr_en,
  input  wire logic [PPF_PE_W-1:0]     i_pe_dir,
  input  wire logic [PPF_PE_W-1:0]     i_pe_dat,
  input  wire logic                    i_pe_serial_en,
  // Peripheral drives
  input  wire logic [PPF_PD_SPI_W-1:0] i_spi_oe,
  input  wire logic [PPF_PD_SPI_W-1:0] i_spi_out,
  input  wire logic [PPF_PD_W-1:0]     i_tmr_oe,
  input  wire logic [PPF_PD_W-1:0]     i_tmr_out,
  input  wire logic                    i_serial_tx,
  // Pin inputs
  input  wire logic [PPF_PA_W-1:0]     i_pa_pin,
  // Pin drive, enable and pullup
  output logic [PPF_PA_W-1:0]          o_pa_oe,
  output logic [PPF_PA_W-1:0]          o_pa_out,
  output logic [PPF_PA_W-1:0]          o_pa_pull,
  output logic [PPF_PA_W-1:0]          o_kbd_in,
  output logic [PPF_PB_W-1:0]          o_pb_oe,
  output logic [PPF_PB_W-1:0]          o_pb_out,
  output logic [PPF_PB_W-1:0]          o_pb_pull,
  output logic [PPF_PB_W-1:0]          o_adc_ch_en,
  output logic [PPF_PC_W-1:0]          o_pc_oe,
  output logic [PPF_PC_W-1:0]          o_pc_out,
  output logic [PPF_PC_W-1:0]          o_pc_pull,
  output logic [PPF_PD_W-1:0]          o_pd_oe,
  output logic [PPF_PD_W-1:0]          o_pd_out,
  output logic [PPF_PD_W-1:0]          o_pd_pull,
  output logic [PPF_PE_W-1:0]          o_pe_oe,
  output logic [PPF_PE_W-1:0]          o_pe_out
);
  localparam int PB_LIVE = SMALL_PKG ? PPF_PB_SMALL : PPF_PB_W;
  localparam logic [PPF_PB_W-1:0] PB_MASK = PPF_PB_W'((1 << PB_LIVE) - 1);
  localparam logic [PPF_PC_W-1:0] PC_MASK = SMALL_PKG ? '0 : '1;
  localparam logic [PPF_PD_W-1:0] PD_TMR_MASK = PPF_PD_W'(7 << PPF_PD_TMR0);

  typedef struct packed {
    logic [PPF_RST_STRETCH-1:0] rst_sh;
    logic                       rst_oe;
    logic                       sys_rst;
    logic                       irq;
    logic [PPF_PA_W-1:0] pa_oe, pa_out, pa_pull, kbd;
    logic [PPF_PB_W-1:0] pb_oe, pb_out, adc;
    logic [PPF_PC_W-1:0] pc_oe, pc_out, pc_pull;
    logic [PPF_PD_W-1:0] pd_oe, pd_out, pd_pull;
    logic [PPF_PE_W-1:0] pe_oe, pe_out;
  } ppf_state_s;

  ppf_state_s st;
  ppf_state_s next_st;

  ppf_pin_if #(.W(PPF_PA_W)) pa ();
  ppf_pin_if #(.W(PPF_PB_W)) pb ();
  ppf_pin_if #(.W(PPF_PC_W)) pc ();
  ppf_pin_if #(.W(PPF_PD_W)) pd ();
  ppf_pin_if #(.W(PPF_PE_W)) pe ();

  ppf_pin_mux #(.W(PPF_PA_W), .HAS_PULL(1'b1)) u_pa (.p(pa));
  ppf_pin_mux #(.W(PPF_PB_W), .HAS_PULL(1'b0)) u_pb (.p(pb));
  ppf_pin_mux #(.W(PPF_PC_W), .HAS_PULL(1'b1)) u_pc (.p(pc));
  ppf_pin_mux #(.W(PPF_PD_W), .HAS_PULL(1'b1)) u_pd (.p(pd));
  ppf_pin_mux #(.W(PPF_PE_W), .HAS_PULL(1'b0)) u_pe (.p(pe));

  // Pullup selects are gated by reset so they read inactive while st.sys_rst is set.
  logic run;
  assign run = ~st.sys_rst;

  // Interrupt catch and its clocked side, declared ahead of the state update.
  logic irq_catch;
  logic irq_sync1;
  logic irq_sync2;
  logic irq_sync3;
  logic irq_seen;
  logic irq_clr;

  always_comb begin
    // Port A: keyboard inputs are input-only, pullup forced on.
    pa.dir           = i_pa_dir;
    pa.dat           = i_pa_dat;
    pa.pull_sel      = run ? i_pa_pull_sel : {PPF_PA_W{PPF_PULL_RST}};
    pa.fn_en         = i_pa_kbd_en;
    pa.fn_oe         = '0;
    pa.fn_out        = '0;
    pa.fn_pull_force = '1;
    // Port B: analog use releases the digital driver.
    pb.dir           = i_pb_dir & PB_MASK;
    pb.dat           = i_pb_dat;
    pb.pull_sel      = '0;
    pb.fn_en         = i_pb_adc_en & PB_MASK;
    pb.fn_oe         = '0;
    pb.fn_out        = '0;
    pb.fn_pull_force = '0;
    // Port C: plain I/O, absent in the small package.
    pc.dir           = i_pc_dir & PC_MASK;
    pc.dat           = i_pc_dat;
    pc.pull_sel      = run ? (i_pc_pull_sel & PC_MASK) : {PPF_PC_W{PPF_PULL_RST}};
    pc.fn_en         = '0;
    pc.fn_oe         = '0;
    pc.fn_out        = '0;
    pc.fn_pull_force = '0;
    // Port D: SPI on the low nibble, timers on the upper three.
    pd.dir           = i_pd_dir;
    pd.dat           = i_pd_dat;
    pd.pull_sel      = run ? i_pd_pull_sel : {PPF_PD_W{PPF_PULL_RST}};
    pd.fn_en         = {3'h0, {PPF_PD_SPI_W{i_pd_spi_en}}} | (i_pd_tmr_en & PD_TMR_MASK);
    pd.fn_oe         = {i_tmr_oe[PPF_PD_W-1:PPF_PD_TMR0], i_spi_oe};
    pd.fn_out        = {i_tmr_out[PPF_PD_W-1:PPF_PD_TMR0], i_spi_out};
    pd.fn_pull_force = '0;
    // Port E: serial transmit drives bit 0, receive makes bit 1 an input.
    pe.dir           = i_pe_dir;
    pe.dat           = i_pe_dat;
    pe.pull_sel      = '0;
    pe.fn_en         = {PPF_PE_W{i_pe_serial_en}};
    pe.fn_oe         = PPF_PE_W'(1 << PPF_PE_TX);
    pe.fn_out        = PPF_PE_W'(i_serial_tx) << PPF_PE_TX;
    pe.fn_pull_force = '0;
  end

  always_comb begin
    next_st = st;
    // Internal sources stretch into a pin drive so the whole board sees it.
    next_st.rst_sh  = {st.rst_sh[PPF_RST_STRETCH-2:0], 1'h0};
    if (i_int_rst_src) begin
      next_st.rst_sh = '1;
    end
    next_st.rst_oe  = i_int_rst_src | (|st.rst_sh);
    // Any low on the pin, from us or the board, holds the system in reset.
    next_st.sys_rst = (i_rst_pin_n == PPF_RST_LVL) | i_int_rst_src;
    next_st.irq     = (st.irq & ~i_irq_ack) | irq_seen;
    next_st.pa_oe   = pa.pin_oe;
    next_st.pa_out  = pa.pin_out;
    next_st.pa_pull = pa.pin_pull;
    next_st.kbd     = ~i_pa_pin & i_pa_kbd_en;
    next_st.pb_oe   = pb.pin_oe & PB_MASK;
    next_st.pb_out  = pb.pin_out & PB_MASK;
    next_st.adc     = i_pb_adc_en & PB_MASK;
    next_st.pc_oe   = pc.pin_oe;
    next_st.pc_out  = pc.pin_out & PC_MASK;
    next_st.pc_pull = pc.pin_pull;
    next_st.pd_oe   = pd.pin_oe;
    next_st.pd_out  = pd.pin_out;
    next_st.pd_pull = pd.pin_pull;
    next_st.pe_oe   = pe.pin_oe;
    next_st.pe_out  = pe.pin_out;
  end

  // The interrupt pin is caught by its falling edge itself, with no clock.
  // The catch flop clears from the clocked side; a new edge wins over the ack.
  always_ff @(negedge i_irq_pin_n or posedge irq_clr) begin
    if (irq_clr) begin
      irq_catch <= 1'h0;
    end else begin
      irq_catch <= 1'h1;
    end
  end
  // One pulse per caught edge, so an ack right after the latch is not undone.
  always_ff @(posedge i_clk) begin
    irq_sync1 <= irq_catch;
    irq_sync2 <= irq_sync1;
    irq_sync3 <= irq_sync2;
  end
  assign irq_seen = irq_sync2 & ~irq_sync3;
  assign irq_clr  = i_rst | (irq_sync2 & st.irq);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st         <= '0;
      st.sys_rst <= 1'h1;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    o_rst_pin_oe  = st.rst_oe;
    o_rst_pin_out = PPF_RST_LVL;
    o_sys_rst     = st.sys_rst;
    o_irq_latched = st.irq;
    o_pa_oe       = st.pa_oe;
    o_pa_out      = st.pa_out;
    o_pa_pull     = st.pa_pull;
    o_kbd_in      = st.kbd;
    o_pb_oe       = st.pb_oe;
    o_pb_out      = st.pb_out;
    o_pb_pull     = '0;
    o_adc_ch_en   = st.adc;
    o_pc_oe       = st.pc_oe;
    o_pc_out      = st.pc_out;
    o_pc_pull     = st.pc_pull;
    o_pd_oe       = st.pd_oe;
    o_pd_out      = st.pd_out;
    o_pd_pull     = st.pd_pull;
    o_pe_oe       = st.pe_oe;
    o_pe_out      = st.pe_out;
  end

  // Pin count check: 4 + 6 + 2 + 7 + 2 general pins.
  localparam int PIN_SUM = PPF_PA_W + PPF_PB_W + PPF_PC_W + PPF_PD_W + PPF_PE_W;

  pin_total_a: assert property (@(posedge i_clk) PIN_SUM == PPF_GPIO_MAX)
    else $error("pin total differs from twenty-one");
  rst_drive_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_int_rst_src |=> o_rst_pin_oe [*4])
    else $error("reset pin not driven after internal reset");
  rst_enter_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rst_pin_n |=> o_sys_rst)
    else $error("low reset pin did not reset system");
  kbd_pull_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pa_kbd_en[0] && !st.sys_rst) |=> o_pa_pull[0])
    else $error("keyboard pin pullup not forced");
  out_nopull_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_pd_dir[6] && !i_pd_tmr_en[6]) |=> !o_pd_pull[6])
    else $error("pullup left on an output pin");
  pb_nopull_a: assert property (@(posedge i_clk) o_pb_pull == '0)
    else $error("port B pullup seen");
  spi_own_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pd_spi_en |=> o_pd_oe[3:0] == $past(i_spi_oe))
    else $error("SPI enable not steering port D");
  pull_rst_a: assert property (@(posedge i_clk)
    st.sys_rst |=> (o_pc_pull == '0))
    else $error("pullup on during reset");
  ser_tx_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pe_serial_en |=> (o_pe_oe[PPF_PE_TX] && !o_pe_oe[PPF_PE_RX]))
    else $error("serial pins not assigned");
  irq_ack_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (o_irq_latched && i_irq_ack && !irq_seen) |=> !o_irq_latched)
    else $error("interrupt flag not cleared by ack");
  adc_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_pb_adc_en[0] |=> !o_pb_oe[0])
    else $error("analog pin still driven");
  small_pkg_a: assert property (@(posedge i_clk)
    !SMALL_PKG || (o_pc_oe == '0 && o_pb_oe[5:4] == 2'h0))
    else $error("absent pins driven in small package");
endmodule

//--- verification/ppf_board_model.sv
// Board circuitry on the port A, reset and interrupt pins.
// Assumes the device drives push-pull; undriven pins without pullup float.
`timescale 1ns/10ps
module ppf_board_model (
  // Clock
  input  wire logic       i_clk,
  // Device pin drives
  input  wire logic [3:0] i_pa_oe,
  input  wire logic [3:0] i_pa_out,
  input  wire logic [3:0] i_pa_pull,
  input  wire logic       i_rst_oe,
  input  wire logic       i_rst_out,
  // Board stimulus
  input  wire logic [3:0] i_key_press,
  input  wire logic       i_rst_btn,
  input  wire logic       i_irq_btn,
  // Resolved pin levels
  output logic [3:0]      o_pa_pin,
  output logic            o_rst_pin_n,
  output logic            o_irq_pin_n
);
  logic [3:0] flt;

  // A floating pin shows a changing level so a missing pullup cannot pass by luck.
  always_ff @(posedge i_clk) begin
    flt <= (flt === 4'h5) ? 4'hA : 4'h5;
  end

  assign o_pa_pin    = (i_pa_oe & i_pa_out) | (~i_pa_oe & ~i_key_press & (i_pa_pull | flt));
  assign o_rst_pin_n = !((i_rst_oe && !i_rst_out) || i_rst_btn);
  assign o_irq_pin_n = !i_irq_btn;
endmodule

//--- verification/ppf_port_pins_test.sv
// Self-checking bench for the port pin function block.
// Assumes registered outputs one cycle after the sampling edge.
`timescale 1ns/10ps
module ppf_port_pins_test;
  import ppf_pkg::*;
  logic i_clk, i_rst, i_rst_pin_n, i_int_rst_src, i_irq_pin_n, i_irq_ack;
  logic i_pd_spi_en, i_pe_serial_en, i_serial_tx, rst_btn, irq_btn;
  logic o_rst_pin_oe, o_rst_pin_out, o_sys_rst, o_irq_latched;
  logic [PPF_PA_W-1:0] i_pa_dir, i_pa_dat, i_pa_pull_sel, i_pa_kbd_en, i_pa_pin, key_press;
  logic [PPF_PA_W-1:0] o_pa_oe, o_pa_out, o_pa_pull, o_kbd_in;
  logic [PPF_PB_W-1:0] i_pb_dir, i_pb_dat, i_pb_adc_en, o_pb_oe, o_pb_out, o_pb_pull;
  logic [PPF_PB_W-1:0] o_adc_ch_en, s_pb_oe, s_adc_ch_en;
  logic [PPF_PC_W-1:0] i_pc_dir, i_pc_dat, i_pc_pull_sel, o_pc_oe, o_pc_out, o_pc_pull, s_pc_oe;
  logic [PPF_PD_W-1:0] i_pd_dir, i_pd_dat, i_pd_pull_sel, i_pd_tmr_en, i_tmr_oe, i_tmr_out;
  logic [PPF_PD_W-1:0] o_pd_oe, o_pd_out, o_pd_pull;
  logic [PPF_PD_SPI_W-1:0] i_spi_oe, i_spi_out;
  logic [PPF_PE_W-1:0] i_pe_dir, i_pe_dat, o_pe_oe, o_pe_out;
  int num_errors, cmp_count, n;

  ppf_port_pins #(.SMALL_PKG(1'b0)) i_dut (.*);
  // The small package shares every input; only its port B and C views are kept.
  ppf_port_pins #(.SMALL_PKG(1'b1)) i_small (.*, .o_rst_pin_oe(), .o_rst_pin_out(),
    .o_sys_rst(), .o_irq_latched(), .o_pa_oe(), .o_pa_out(), .o_pa_pull(), .o_kbd_in(),
    .o_pb_oe(s_pb_oe), .o_pb_out(), .o_pb_pull(), .o_adc_ch_en(s_adc_ch_en),
    .o_pc_oe(s_pc_oe), .o_pc_out(), .o_pc_pull(), .o_pd_oe(), .o_pd_out(), .o_pd_pull(),
    .o_pe_oe(), .o_pe_out());
  ppf_board_model i_board (.i_clk(i_clk), .i_pa_oe(o_pa_oe), .i_pa_out(o_pa_out),
    .i_pa_pull(o_pa_pull), .i_rst_oe(o_rst_pin_oe), .i_rst_out(o_rst_pin_out),
    .i_key_press(key_press), .i_rst_btn(rst_btn), .i_irq_btn(irq_btn),
    .o_pa_pin(i_pa_pin), .o_rst_pin_n(i_rst_pin_n), .o_irq_pin_n(i_irq_pin_n));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    @(posedge i_clk);
    @(negedge i_clk);
  endtask

  task automatic wait_sys_clear();
    for (int k = 0; k < 20 && o_sys_rst !== 1'b0; k++) @(posedge i_clk);
    @(negedge i_clk);
    check(o_sys_rst, 1'h0);
  endtask

  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    num_errors++;
    finish_test();
  end

  initial begin
    i_rst = 1'b1;
    {i_int_rst_src, i_irq_ack, i_pd_spi_en, i_pe_serial_en, i_serial_tx, rst_btn, irq_btn} = '0;
    {i_pa_dir, i_pa_dat, key_press, i_pb_dir, i_pb_dat, i_pb_adc_en, i_pc_dir, i_pc_dat} = '0;
    {i_pd_dir, i_pd_dat, i_pd_tmr_en, i_tmr_oe, i_tmr_out, i_spi_oe, i_spi_out} = '0;
    {i_pe_dir, i_pe_dat} = '0;
    {i_pa_pull_sel, i_pa_kbd_en, i_pc_pull_sel, i_pd_pull_sel} = '1;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    check(o_sys_rst, 1'h1);
    check({o_pa_pull, o_pc_pull, o_pd_pull}, 13'h0000);
    @(posedge i_clk);
    i_rst <= 1'b0;
    wait_sys_clear();
    check($bits(o_pa_oe) + $bits(o_pb_oe) + $bits(o_pc_oe) + $bits(o_pd_oe) + $bits(o_pe_oe), 21);
    check($bits(o_pa_oe) + $bits(o_pb_oe) + $bits(o_pd_oe) + $bits(o_pe_oe), 19);
    @(posedge i_clk);
    i_pa_kbd_en <= 4'h0;
    i_pa_dir <= 4'h5;
    i_pa_dat <= 4'hF;
    i_pc_dir <= 2'h1;
    i_pd_dir <= 7'h4F;
    settle();
    check(o_pa_pull, 4'hA);
    check(o_pc_pull, 2'h2);
    check(o_pd_pull, 7'h30);
    check(o_pa_oe & o_pa_out, 4'h5);
    for (n = 0; n < 16; n++) begin
      @(posedge i_clk);
      i_pa_kbd_en <= n[3:0];
      i_pa_pull_sel <= 4'h0;
      i_pa_dir <= 4'hF;
      settle();
      check(o_pa_pull, n[3:0]);
      check(o_pa_oe, 4'(~n[3:0]));
    end
    @(posedge i_clk);
    i_pa_kbd_en <= 4'h1;
    key_press <= 4'h3;
    settle();
    check(o_kbd_in, 4'h1);
    @(posedge i_clk);
    key_press <= 4'h0;
    i_pb_dir <= 6'h3F;
    i_pb_dat <= 6'h2A;
    i_pc_dir <= 2'h3;
    i_pc_dat <= 2'h2;
    settle();
    check({o_pb_oe, o_pb_out, o_pb_pull}, 18'h3_FA80);
    check(o_pc_out, 2'h2);
    check({s_pb_oe, s_pc_oe}, 8'h3C);
    @(posedge i_clk);
    i_pb_adc_en <= 6'h3F;
    settle();
    check({o_adc_ch_en, o_pb_pull}, 12'hFC0);
    check(o_pb_oe, 6'h00);
    check(s_adc_ch_en, 6'h0F);
    @(posedge i_clk);
    i_pd_dir <= 7'h00;
    i_pd_pull_sel <= 7'h7F;
    i_pd_spi_en <= 1'b1;
    i_spi_oe <= 4'h3;
    i_spi_out <= 4'h1;
    i_pd_tmr_en <= 7'h50;
    i_tmr_oe <= 7'h50;
    i_tmr_out <= 7'h10;
    settle();
    check(o_pd_oe, 7'h53);
    check(o_pd_out & 7'h53, 7'h11);
    check(o_pd_pull, 7'h2C);
    @(posedge i_clk);
    i_pd_spi_en <= 1'b0;
    i_pd_tmr_en <= 7'h00;
    settle();
    check(o_pd_oe, 7'h00);
    @(posedge i_clk);
    i_pe_dir <= 2'h3;
    i_pe_dat <= 2'h2;
    i_pe_serial_en <= 1'b1;
    i_serial_tx <= 1'b1;
    settle();
    check({o_pe_oe, o_pe_out}, 4'h5);
    @(posedge i_clk);
    i_int_rst_src <= 1'b1;
    @(posedge i_clk);
    i_int_rst_src <= 1'b0;
    @(negedge i_clk);
    check({o_rst_pin_oe, o_rst_pin_out}, 2'h2);
    repeat (PPF_RST_STRETCH) @(posedge i_clk);
    @(negedge i_clk);
    check({o_rst_pin_oe, o_sys_rst, o_pd_pull}, 9'h180);
    settle();
    check(o_rst_pin_oe, 1'h0);
    wait_sys_clear();
    @(posedge i_clk);
    rst_btn <= 1'b1;
    settle();
    check({o_sys_rst, o_rst_pin_oe}, 2'h2);
    @(posedge i_clk);
    rst_btn <= 1'b0;
    wait_sys_clear();
    // A short pulse between edges is only seen if the pin is taken without the clock.
    #1 irq_btn = 1'b1;
    #2 irq_btn = 1'b0;
    for (n = 0; n < 6 && o_irq_latched !== 1'b1; n++) @(negedge i_clk);
    check(o_irq_latched, 1'h1);
    @(posedge i_clk);
    i_irq_ack <= 1'b1;
    @(posedge i_clk);
    i_irq_ack <= 1'b0;
    @(negedge i_clk);
    check(o_irq_latched, 1'h0);
    finish_test();
  end
endmodule
